// File: common/adc_params.svh
// Offsets, codes and timing counts of the converter sequencing block.
// Assumes inclusion by bare name from the design and testbench files.
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// ---------------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------------
`define OFS_CTL1 32'h0000_0000
`define OFS_CTL2 32'h0000_0004
`define OFS_CTL3 32'h0000_0008
`define OFS_SCAN 32'h0000_000C
`define OFS_BUF_LO 32'h0000_0040
`define OFS_BUF_HI 32'h0000_0080
// ---------------------------------------------------------------------
// Writable bits and reset values
// ---------------------------------------------------------------------
`define CTL1_WMASK 16'hA7EC
`define CTL2_WMASK 16'hE73F
`define CTL3_WMASK 16'h9FFF
`define SCAN_WMASK 16'h01FF
`define REG_RESET 16'h0000
`define SCAN_INPUTS 9
// ---------------------------------------------------------------------
// Field codes
// ---------------------------------------------------------------------
`define SSRC_SOFT 3'h0
`define SSRC_PIN 3'h1
`define SSRC_TIMER3 3'h2
`define SSRC_PWM1 3'h3
`define SSRC_PWM2 3'h5
`define SSRC_AUTO 3'h7
`define FORM_INT 2'h0
`define FORM_SINT 2'h1
`define FORM_FRAC 2'h2
`define FORM_SFRAC 2'h3
`define CHPS_ONE 2'h0
`define CHPS_TWO 2'h1
`define VCFG_POS 3'h1
`define VCFG_NEG 3'h2
`define VCFG_BOTH 3'h3
// ---------------------------------------------------------------------
// Timing in conversion clock periods
// ---------------------------------------------------------------------
`define CONV_TAD_10 4'hC
`define CONV_TAD_12 4'hE
// ---------------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// File: common/adc_pkg.sv
// Types shared by the converter sequencing block and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_pkg;
  typedef enum logic [1:0] {ST_HOLD, ST_SAMPLE, ST_CONVERT} seq_state_e;
  typedef struct packed {
    logic on; logic r14; logic sidl; logic [1:0] r12; logic res;
    logic [1:0] form; logic [2:0] ssrc; logic r4; logic simultaneous_sample;
    logic auto_sample_start; logic sample_bit; logic done;
  } ctl1_s;
  typedef struct packed {
    logic [2:0] vcfg; logic [1:0] r12; logic scan; logic [1:0] chps;
    logic buffer_half_status; logic r6; logic [3:0] smpi; logic split_buffer_mode; logic alternate_sampling;
  } ctl2_s;
  typedef struct packed {
    logic rc; logic [1:0] r14; logic [4:0] samc; logic [7:0] adcs;
  } ctl3_s;
  typedef struct packed {
    logic pwm1; logic pwm2; logic timer3;
  } trig_s;
  typedef struct packed {
    logic enable; logic [3:0] sample_hold; logic convert;
    logic [1:0] channel; logic sample_b; logic scan_active;
    logic [3:0] scan_input; logic ref_pos_ext; logic ref_neg_ext;
  } analog_s;
endpackage

// File: src/adc_sequence_control.sv
// Sequencing and control logic of a successive-approximation converter.
// Assumes aclk is the instruction clock; the analog array returns a
// raw code on analog_result that is valid when a channel's time ends.
`timescale 1ns/1ns
`default_nettype none
`include "adc_params.svh"
module adc_sequence_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic device_idle,
  input wire adc_pkg::trig_s triggers,
  input wire logic external_interrupt_pin,
  input wire logic rc_clock_pin,
  input wire logic [11:0] analog_result,
  output adc_pkg::analog_s analog,
  output logic interval_event
);
  // -------------------------------------------------------------------
  // Bus slave
  // -------------------------------------------------------------------
  logic aw_held, w_held;
  logic [31:0] aw_addr, w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  logic wr_map;
  assign wr_map = aw_addr == `OFS_CTL1 || aw_addr == `OFS_CTL2 ||
                  aw_addr == `OFS_CTL3 || aw_addr == `OFS_SCAN;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_map ? `RESP_OKAY : `RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Byte-lane merge limited to implemented bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{w_strb[1]}}, {8{w_strb[0]}}} & mask;
    merge = (old & ~m) | (w_data[15:0] & m);
  endfunction

  logic wr_ctl1, wr_ctl2, wr_ctl3, wr_scan;
  assign wr_ctl1 = wr_fire && aw_addr == `OFS_CTL1;
  assign wr_ctl2 = wr_fire && aw_addr == `OFS_CTL2;
  assign wr_ctl3 = wr_fire && aw_addr == `OFS_CTL3;
  assign wr_scan = wr_fire && aw_addr == `OFS_SCAN;

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  adc_pkg::ctl1_s ctl1;
  adc_pkg::ctl2_s ctl2;
  adc_pkg::ctl3_s ctl3;
  logic [15:0] scan_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) ctl1 <= adc_pkg::ctl1_s'(`REG_RESET);
    else if (wr_ctl1) ctl1 <= adc_pkg::ctl1_s'(merge(ctl1, `CTL1_WMASK));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ctl2 <= adc_pkg::ctl2_s'(`REG_RESET);
    else if (wr_ctl2) ctl2 <= adc_pkg::ctl2_s'(merge(ctl2, `CTL2_WMASK));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ctl3 <= adc_pkg::ctl3_s'(`REG_RESET);
    else if (wr_ctl3) ctl3 <= adc_pkg::ctl3_s'(merge(ctl3, `CTL3_WMASK));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) scan_sel <= `REG_RESET;
    else if (wr_scan) scan_sel <= merge(scan_sel, `SCAN_WMASK);
  end

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  logic [1:0] pin_sync, rc_sync;
  logic pin_last, rc_last;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync <= 2'h0;
      rc_sync <= 2'h0;
      pin_last <= 1'b0;
      rc_last <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], external_interrupt_pin};
      rc_sync <= {rc_sync[0], rc_clock_pin};
      pin_last <= pin_sync[1];
      rc_last <= rc_sync[1];
    end
  end
  // Rising edge is the active transition of the pin
  logic pin_edge, rc_edge;
  assign pin_edge = pin_sync[1] && !pin_last;
  assign rc_edge = rc_sync[1] && !rc_last;

  // -------------------------------------------------------------------
  // Effective mode
  // -------------------------------------------------------------------
  adc_pkg::seq_state_e state;
  logic run, simultaneous_sample_eff, tad_tick, hw_trig, start_conv, seq_end, chan_end;
  logic sw_start, sw_end, sw_done_clr, interval_hit, sample_b, half;
  logic [1:0] chps_eff, last_chan, chan_idx;
  logic [3:0] conv_cnt, conv_len, seq_cnt, wptr, scan_idx, scan_next;
  logic [4:0] sample_bit_cnt;
  logic [7:0] tcy_cnt;

  assign run = ctl1.on && !(ctl1.sidl && device_idle);
  assign chps_eff = ctl1.res ? `CHPS_ONE : ctl2.chps;
  assign simultaneous_sample_eff = !ctl1.res && ctl1.simultaneous_sample;
  assign last_chan = chps_eff == `CHPS_ONE ? 2'h0 :
                     chps_eff == `CHPS_TWO ? 2'h1 : 2'h3;
  assign conv_len = ctl1.res ? `CONV_TAD_12 : `CONV_TAD_10;

  // -------------------------------------------------------------------
  // Conversion clock
  // -------------------------------------------------------------------
  assign tad_tick = ctl3.rc ? rc_edge : tcy_cnt == ctl3.adcs;
  always_ff @(posedge aclk) begin
    // Restart at conversion start so with the divided clock every channel spans whole periods
    if (!aresetn || !ctl1.on || ctl3.rc || tad_tick || start_conv) tcy_cnt <= 8'h0;
    else if (run) tcy_cnt <= tcy_cnt + 8'h1;
  end

  // -------------------------------------------------------------------
  // Trigger and software strobes
  // -------------------------------------------------------------------
  always_comb begin
    case (ctl1.ssrc)
      `SSRC_AUTO: hw_trig = sample_bit_cnt == ctl3.samc;
      `SSRC_PWM2: hw_trig = triggers.pwm2;
      `SSRC_PWM1: hw_trig = triggers.pwm1;
      `SSRC_TIMER3: hw_trig = triggers.timer3;
      `SSRC_PIN: hw_trig = pin_edge;
      default: hw_trig = 1'b0;
    endcase
  end

  assign sw_start = wr_ctl1 && w_strb[0] && w_data[1];
  assign sw_end = wr_ctl1 && w_strb[0] && !w_data[1] &&
                  ctl1.ssrc == `SSRC_SOFT;
  assign sw_done_clr = wr_ctl1 && w_strb[0] && !w_data[0];
  assign start_conv = run && state == adc_pkg::ST_SAMPLE &&
                      (ctl1.ssrc == `SSRC_SOFT ? sw_end : hw_trig);
  assign chan_end = run && state == adc_pkg::ST_CONVERT && tad_tick &&
                    conv_cnt == conv_len - 4'h1;
  assign seq_end = chan_end && chan_idx == last_chan;
  assign interval_hit = seq_cnt == ctl2.smpi;

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl1.on) begin
      state <= adc_pkg::ST_HOLD;
    end else if (run) begin
      case (state)
        adc_pkg::ST_HOLD: begin
          if (sw_start || ctl1.auto_sample_start) state <= adc_pkg::ST_SAMPLE;
        end
        adc_pkg::ST_SAMPLE: begin
          if (start_conv) state <= adc_pkg::ST_CONVERT;
        end
        adc_pkg::ST_CONVERT: begin
          if (seq_end) begin
            state <= ctl1.auto_sample_start ? adc_pkg::ST_SAMPLE : adc_pkg::ST_HOLD;
          end
        end
        default: state <= adc_pkg::ST_HOLD;
      endcase
    end
  end

  // Sampling length counted only in conversion clocks while sampling
  always_ff @(posedge aclk) begin
    if (!aresetn || state != adc_pkg::ST_SAMPLE) sample_bit_cnt <= 5'h0;
    else if (run && tad_tick && sample_bit_cnt != ctl3.samc) sample_bit_cnt <= sample_bit_cnt + 5'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != adc_pkg::ST_CONVERT || chan_end) conv_cnt <= 4'h0;
    else if (run && tad_tick) conv_cnt <= conv_cnt + 4'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start_conv) chan_idx <= 2'h0;
    else if (chan_end && !seq_end) chan_idx <= chan_idx + 2'h1;
  end

  // Completion wins over a software clear in the same cycle
  logic done;
  always_ff @(posedge aclk) begin
    if (!aresetn) done <= 1'b0;
    else if (seq_end) done <= 1'b1;
    else if (start_conv || sw_done_clr) done <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl1.on) seq_cnt <= 4'h0;
    else if (seq_end) seq_cnt <= interval_hit ? 4'h0 : seq_cnt + 4'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) interval_event <= 1'b0;
    else interval_event <= seq_end && interval_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl2.alternate_sampling) sample_b <= 1'b0;
    else if (seq_end) sample_b <= !sample_b;
  end

  // -------------------------------------------------------------------
  // Result buffer
  // -------------------------------------------------------------------
  logic [15:0] result_buf [16];
  logic [15:0] fmt_result;
  logic [9:0] d10;
  logic [11:0] d12;
  assign d10 = analog_result[9:0];
  assign d12 = analog_result;
  always_comb begin
    case ({ctl1.res, ctl1.form})
      {1'b0, `FORM_INT}: fmt_result = {6'h0, d10};
      {1'b0, `FORM_SINT}: fmt_result = {{7{~d10[9]}}, d10[8:0]};
      {1'b0, `FORM_FRAC}: fmt_result = {d10, 6'h0};
      {1'b0, `FORM_SFRAC}: fmt_result = {~d10[9], d10[8:0], 6'h0};
      {1'b1, `FORM_INT}: fmt_result = {4'h0, d12};
      {1'b1, `FORM_SINT}: fmt_result = {{5{~d12[11]}}, d12[10:0]};
      {1'b1, `FORM_FRAC}: fmt_result = {d12, 4'h0};
      default: fmt_result = {~d12[11], d12[10:0], 4'h0};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (chan_end) result_buf[wptr] <= fmt_result;
  end

  // Split mode keeps the pointer inside the active eight-word half
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl1.on) begin
      wptr <= 4'h0;
      half <= 1'b0;
    end else if (seq_end && interval_hit) begin
      half <= ctl2.split_buffer_mode && !half;
      wptr <= {ctl2.split_buffer_mode && !half, 3'h0};
    end else if (chan_end) begin
      wptr <= ctl2.split_buffer_mode ? {half, wptr[2:0] + 3'h1} : wptr + 4'h1;
    end
  end

  // -------------------------------------------------------------------
  // Input scan
  // -------------------------------------------------------------------
  always_comb begin
    int idx;
    idx = 0;
    scan_next = scan_idx;
    for (int k = `SCAN_INPUTS; k >= 1; k--) begin
      idx = (int'(scan_idx) + k) % `SCAN_INPUTS;
      if (scan_sel[idx]) scan_next = 4'(idx);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl2.scan) scan_idx <= 4'h0;
    else if (chan_end && chan_idx == 2'h0 && !sample_b) scan_idx <= scan_next;
  end

  // -------------------------------------------------------------------
  // Analog array control
  // -------------------------------------------------------------------
  logic [3:0] hold_next;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sh
      logic active;
      assign active = 2'(g) <= last_chan;
      assign hold_next[g] = active && run &&
        (state == adc_pkg::ST_SAMPLE ||
         (state == adc_pkg::ST_CONVERT && !simultaneous_sample_eff && 2'(g) > chan_idx));
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog <= '0;
    end else begin
      analog.enable <= run;
      analog.sample_hold <= hold_next;
      analog.convert <= run && state == adc_pkg::ST_CONVERT;
      analog.channel <= chan_idx;
      analog.sample_b <= sample_b;
      analog.scan_active <= ctl2.scan && !sample_b;
      analog.scan_input <= scan_idx;
      analog.ref_pos_ext <= ctl2.vcfg == `VCFG_POS || ctl2.vcfg == `VCFG_BOTH;
      analog.ref_neg_ext <= ctl2.vcfg == `VCFG_NEG || ctl2.vcfg == `VCFG_BOTH;
    end
  end

  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------
  adc_pkg::ctl1_s rd1;
  adc_pkg::ctl2_s rd2;
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd1 = ctl1;
    rd1.simultaneous_sample = simultaneous_sample_eff;
    rd1.sample_bit = state == adc_pkg::ST_SAMPLE;
    rd1.done = done;
    rd2 = ctl2;
    rd2.chps = chps_eff;
    rd2.buffer_half_status = half;
    rd_hit = 1'b1;
    rd_word = 32'h0;
    if (araddr == `OFS_CTL1) rd_word = {16'h0, rd1};
    else if (araddr == `OFS_CTL2) rd_word = {16'h0, rd2};
    else if (araddr == `OFS_CTL3) rd_word = {16'h0, ctl3};
    else if (araddr == `OFS_SCAN) rd_word = {16'h0, scan_sel};
    else if (araddr >= `OFS_BUF_LO && araddr < `OFS_BUF_HI) rd_word = {16'h0, result_buf[araddr[5:2]]};
    else rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/adc_sequence_control_properties.sv
// Port checks for the converter sequencing block.
// Assumes bus writes offer address and data together.
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_control_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire adc_pkg::analog_s analog,
  input wire logic interval_event
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic res, sim, auto_sample_start;
  logic [1:0] chps;
  wire wr = awvalid && awready && wvalid && wready;
  // Shadow of the mode bits, taken from the write traffic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {res, sim, auto_sample_start, chps} <= 5'h00;
    end else if (wr && awaddr == 32'h0) begin
      {res, sim, auto_sample_start} <= {wdata[10], wdata[3], wdata[2]};
    end else if (wr && awaddr == 32'h4) begin
      chps <= wdata[9:8];
    end
  end
  property p_off;
    !analog.enable |-> !analog.convert && analog.sample_hold == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("converter active while off");
  property p_one_chan;
    analog.convert && (res || chps == 2'h0) |-> analog.channel == 2'h0;
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("channel beyond 0");
  property p_two_chan;
    analog.convert && !res && chps == 2'h1 |-> analog.channel <= 2'h1;
  endproperty
  a_two_chan: assert property (p_two_chan) else $error("channel beyond 1");
  property p_conv_start;
    $rose(analog.convert) |-> $past(analog.sample_hold[0]);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("convert without sampling");
  property p_simul;
    $fell(analog.sample_hold[0]) && sim && !res && chps[1] |-> analog.sample_hold == 4'h0;
  endproperty
  a_simul: assert property (p_simul) else $error("holds not together");
  property p_restart;
    $fell(analog.convert) && analog.enable && auto_sample_start && (res || chps == 2'h0) |-> ##[1:4] analog.sample_hold[0];
  endproperty
  a_restart: assert property (p_restart) else $error("no auto restart");
  property p_event;
    interval_event |-> ($past(analog.convert) || $past(analog.convert, 2)) ##1 !interval_event;
  endproperty
  a_event: assert property (p_event) else $error("interval pulse misplaced");
  property p_wack;
    wr |=> ##1 bvalid;
  endproperty
  a_wack: assert property (p_wack) else $error("write not answered");
  property p_rack;
    arvalid && arready |=> rvalid;
  endproperty
  a_rack: assert property (p_rack) else $error("read not answered");
  c_conv: cover property ($rose(analog.convert));
  c_event: cover property (interval_event);
  c_four: cover property (analog.sample_hold == 4'hF);
endmodule
bind adc_sequence_control adc_sequence_control_properties chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .analog(analog), .interval_event(interval_event));
`default_nettype wire

// File: verif/adc_front_model.sv
// Analog array and trigger sources facing the block.
// Assumes the block's clock; fire picks a trigger code for one cycle.
`timescale 1ns/1ns
`default_nettype none
module adc_front_model (
  input wire logic aclk,
  input wire adc_pkg::analog_s analog,
  input wire logic [2:0] fire,
  output adc_pkg::trig_s triggers,
  output logic pin,
  output logic [11:0] code
);
  initial code = 12'h000;
  // Off conversion the code toggles so a stale value matches only on every other cycle
  always_ff @(posedge aclk) begin
    code <= analog.convert ? 12'h25C + {10'h000, analog.channel} : ~code;
    triggers <= {fire == 3'h3, fire == 3'h5, fire == 3'h2};
    pin <= fire == 3'h1;
  end
endmodule
`default_nettype wire

// File: verif/tb_adc_sequence_control.sv
// Register-level tests of the converter sequencing block.
// Assumes the block's header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "adc_params.svh"
module tb_adc_sequence_control;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, device_idle, rc_clk, pin, ok;
  logic awready, wready, bvalid, arready, rvalid, interval_event;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic [2:0] fire;
  logic [1:0] bresp, rresp, r;
  logic [11:0] code;
  logic [15:0] b;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  adc_pkg::trig_s trig;
  adc_pkg::analog_s analog;
  int miscompares, cmp_count, ccount, evcount, c0, e0;
  adc_sequence_control DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .device_idle(device_idle),
    .triggers(trig), .external_interrupt_pin(pin), .rc_clock_pin(rc_clk), .analog_result(code),
    .analog(analog), .interval_event(interval_event));
  adc_front_model front (.aclk(aclk), .analog(analog), .fire(fire), .triggers(trig), .pin(pin), .code(code));
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  // Free-running RC source, eight aclk periods long at a fixed 1 ns offset
  initial begin
    rc_clk = 0;
    #1;
    forever #16 rc_clk = ~rc_clk;
  end
  always @(posedge aclk) begin
    ccount <= ccount + int'(analog.convert);
    evcount <= evcount + int'(interval_event);
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, d);
  endtask
  task automatic wait_done;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      rd(`OFS_CTL1);
      ok = d[0];
    end
    chk("done", 1, ok);
  endtask
  task automatic conv(input logic [15:0] v);
    wr(`OFS_CTL1, v);
    wr(`OFS_CTL1, v | 16'h0002);
    wr(`OFS_CTL1, v);
    wait_done();
  endtask
  function automatic logic [15:0] fmt(input logic s, input logic [1:0] f, input logic [11:0] c);
    case (f)
      2'h0: fmt = s ? {4'h0, c} : {6'h00, c[9:0]};
      2'h1: fmt = s ? {{5{~c[11]}}, c[10:0]} : {{7{~c[9]}}, c[8:0]};
      2'h2: fmt = s ? {c, 4'h0} : {c[9:0], 6'h00};
      default: fmt = s ? {~c[11], c[10:0], 4'h0} : {~c[9], c[8:0], 6'h00};
    endcase
  endfunction
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    close_out();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, device_idle} = 7'h00;
    {awaddr, wdata, araddr, fire, ccount, evcount} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rc(4 * i, `REG_RESET, "reset value");
    rd(32'h20);
    chk("unmapped", `RESP_DECERR, r);
    wr(`OFS_CTL3, 16'hFFFF);
    rc(`OFS_CTL3, 16'h9FFF, "ctl3");
    wr(`OFS_CTL1, 16'h0408);
    rc(`OFS_CTL1, 16'h0400, "ctl1 12b");
    wr(`OFS_CTL2, 16'hFFFF);
    rc(`OFS_CTL2, 16'hE43F, "ctl2 12b");
    wr(`OFS_CTL2, 16'h0000);
    wr(`OFS_CTL3, 16'h0000);
    wr(`OFS_CTL1, 16'h0002);
    chk("off hold", 0, analog.sample_hold);
    for (int i = 0; i < 8; i++) begin
      b = {1'b1, 4'h0, i[2], i[1:0], 8'h00};
      wr(`OFS_CTL1, 16'h0000);
      conv(b);
      rc(`OFS_BUF_LO, {16'h0000, fmt(i[2], i[1:0], 12'h25C)}, "result");
    end
    wr(`OFS_CTL1, 16'h0000);
    wr(`OFS_CTL1, 16'h8001);
    rc(`OFS_CTL1, 16'h8000, "done set");
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_CTL2, {i[2:0], 13'h0000});
      chk("refs", i[2] ? 2'h0 : {i[0], i[1]}, {analog.ref_pos_ext, analog.ref_neg_ext});
    end
    wr(`OFS_CTL2, 16'h0300);
    conv(16'h8008);
    for (int k = 0; k < 4; k++) rc(`OFS_BUF_LO + 4 * k, 16'h025C + k, "channel");
    wr(`OFS_CTL2, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      wr(`OFS_CTL1, 16'h0000);
      wr(`OFS_CTL1, {8'h80, codes[k], 5'h00});
      wr(`OFS_CTL1, {8'h80, codes[k], 5'h02});
      fire <= codes[k];
      @(posedge aclk);
      fire <= 3'h0;
      wait_done();
      chk("sample_bit cleared", 0, d[1]);
    end
    wr(`OFS_CTL1, 16'h0000);
    wr(`OFS_CTL1, 16'h8080);
    wr(`OFS_CTL1, 16'h8082);
    fire <= 3'h4;
    repeat (100) @(posedge aclk);
    rc(`OFS_CTL1, 16'h8082, "reserved");
    wr(`OFS_CTL1, 16'h0000);
    wr(`OFS_CTL3, 16'h0003);
    c0 = ccount;
    conv(16'h8000);
    chk("tad length", 48, ccount - c0);
    wr(`OFS_CTL3, 16'h80FF);
    c0 = ccount;
    conv(16'h8000);
    chk("rc clock", 1, ccount - c0 < 200);
    wr(`OFS_CTL3, 16'h0000);
    wr(`OFS_CTL1, 16'h0000);
    wr(`OFS_CTL1, 16'hA000);
    wr(`OFS_CTL1, 16'hA002);
    device_idle <= 1'b1;
    wr(`OFS_CTL1, 16'hA0E2);
    repeat (60) @(posedge aclk);
    rc(`OFS_CTL1, 16'hA0E2, "idle stop");
    device_idle <= 1'b0;
    wait_done();
    wr(`OFS_CTL1, 16'h0000);
    wr(`OFS_CTL2, 16'h0006);
    e0 = evcount;
    conv(16'h8000);
    rc(`OFS_CTL2, 16'h0006, "first half");
    chk("no event", e0, evcount);
    conv(16'h8000);
    rc(`OFS_CTL2, 16'h0086, "second half");
    chk("event", e0 + 1, evcount);
    rc(`OFS_BUF_LO + 4, 16'h025C, "next entry");
    wr(`OFS_CTL1, 16'h0000);
    wr(`OFS_CTL2, 16'h0000);
    conv(16'h8004);
    rc(`OFS_CTL1, 16'h8007, "auto restart");
    close_out();
  end
endmodule
`default_nettype wire
